/* design/ttc_top.sv */
/*
 * ttc_top: three timer/counters with an 8-bit register port.
 * Assumes pins are asynchronous; one clock ref_clk, reset rst.
 */
// The strobed register port was decided locally.
// Notes on behaviour
// - mode 00: 13-bit count, low 5 bits carry into high byte.
// - first timer runs when run bit set and gate off or irq pin high.
// - source bit 0 counts clock ticks, 1 counts falling pin edges.
// - 13-bit rollover from 1FFF to 0 sets first overflow flag.
// - second timer mirrors first, except split mode, with own bits.
// - mode 01: 16-bit counter, rollover after FFFF sets flag.
// - mode 10: low byte counts, reloads from high byte past FF.
// - split mode: first low byte is normal 8-bit timer/counter.
// - split mode: first high byte counts clocks, second run/flag.
// - second timer in split mode holds its value.
// - first in split: second counts clocks only, sets no flag.
// - third timer 16-bit, clock ticks or falling pin edges.
// - third timer counts only while its run bit is set.
// - third overflow past FFFF sets third overflow flag; it goes to 0 only in capture mode.
// - capture mode with trigger enable: falling trigger captures count.
// - reload mode: overflow sets flag and reloads from reload bytes.
// - reload mode: enabled falling trigger forces immediate reload.
// - third time base: quarter bit gives /4, full bit gives /1.
// - after reset every time base is clock divided by 12.
// - full-rate bit set makes quarter-rate bit ignored.
// - pin edge needs two samples high then two low.
// - down count disabled: third timer counts up only.
`timescale 1ns/1ps
module ttc_top
   import ttc_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       rst,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr_en,
   input  wire logic       rd_en,
   output logic [7:0]      rdata,
   input  wire logic       ext_irq_pin_a,
   input  wire logic       ext_irq_pin_b,
   input  wire logic       count_pin_first,
   input  wire logic       count_pin_second,
   input  wire logic       count_pin_third,
   input  wire logic       trigger_pin_third,
   output logic            ovf_first,
   output logic            ovf_second,
   output logic            ovf_third
);
   localparam int NPIN = 6;
   logic [NPIN-1:0] pin_raw;
   logic [NPIN-1:0] s1_reg, s2_reg, s3_reg, lvl_reg, prev_reg;
   logic [NPIN-1:0] fall;
   assign pin_raw = {trigger_pin_third, count_pin_third, count_pin_second,
                     count_pin_first, ext_irq_pin_b, ext_irq_pin_a};

   // sync; level accepted once stages 2 and 3 agree
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         s1_reg   <= '1;
         s2_reg   <= '1;
         s3_reg   <= '1;
         lvl_reg  <= '1;
         prev_reg <= '1;
      end else begin
         s1_reg <= pin_raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         for (int i = 0; i < NPIN; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               lvl_reg[i] <= s3_reg[i];
            end
         end
         prev_reg <= lvl_reg;
      end
   end

   // edge counted after two high then two low samples
   logic [NPIN-1:0] h1_reg, h2_reg;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         h1_reg <= '1;
         h2_reg <= '1;
      end else begin
         h1_reg <= prev_reg;
         h2_reg <= h1_reg;
      end
   end
   assign fall = h2_reg & h1_reg & ~prev_reg & ~lvl_reg;

   // registers
   ttc_cfg_s cfg1_reg, cfg2_reg;
   logic [7:0] run_flag_reg, clk_div_reg, clk_fast_reg;
   logic [7:0] t3_ctrl_reg, t3_opt_reg, rld_lo_reg, rld_hi_reg;
   logic [7:0] lo1_reg, hi1_reg, lo2_reg, hi2_reg, lo3_reg, hi3_reg;

   // time-base ticks
   logic [3:0] div12_reg;
   logic [1:0] div4_reg;
   logic       tick12, tick4;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         div12_reg <= 4'h0;
         div4_reg  <= 2'h0;
      end else begin
         div12_reg <= (div12_reg == 4'(LEGACY_DIV - 1)) ? 4'h0
                      : div12_reg + 4'h1;
         div4_reg  <= div4_reg + 2'h1;
      end
   end
   assign tick12 = (div12_reg == 4'(LEGACY_DIV - 1));
   assign tick4  = (div4_reg == 2'(QUARTER_DIV - 1));

   function automatic logic base_tick(input logic full, input logic quarter,
                                      input logic t12, input logic t4);
      base_tick = full ? 1'b1 : (quarter ? t4 : t12);
   endfunction : base_tick

   logic tb1, tb2, tb3;
   assign tb1 = base_tick(clk_fast_reg[FULL_BIT0], clk_div_reg[QUARTER_BIT0],
                          tick12, tick4);
   assign tb2 = base_tick(clk_fast_reg[FULL_BIT0+1],
                          clk_div_reg[QUARTER_BIT0+1], tick12, tick4);
   assign tb3 = base_tick(clk_fast_reg[FULL_BIT0+2],
                          clk_div_reg[QUARTER_BIT0+2], tick12, tick4);

   // count enables
   logic split1, en1, en1h, en2, inc3;
   assign split1 = (cfg1_reg.mode == TTC_SPLIT);
   assign en1 = run_flag_reg[RUN1_BIT]
              & (~cfg1_reg.gate | lvl_reg[0])
              & (cfg1_reg.src ? fall[2] : tb1);
   assign en1h = split1 & run_flag_reg[RUN2_BIT] & tb1;
   assign en2 = (cfg2_reg.mode != TTC_SPLIT)
              & (split1 ? tb2
                 : run_flag_reg[RUN2_BIT]
                   & (~cfg2_reg.gate | lvl_reg[1])
                   & (cfg2_reg.src ? fall[3] : tb2));
   assign inc3 = t3_ctrl_reg[T3_RUN_BIT]
               & (t3_ctrl_reg[T3_SRC_BIT] ? fall[4] : tb3);

   // shared counter step for the first two timers
   function automatic logic [16:0] step(input ttc_mode_e m,
                                        input logic [7:0] lo,
                                        input logic [7:0] hi);
      logic [13:0] c13;
      logic [16:0] c16;
      logic [8:0]  c8;
      c13 = {1'b0, hi, lo[4:0]} + 14'h1;
      c16 = {1'b0, hi, lo} + 17'h1;
      c8  = {1'b0, lo} + 9'h1;
      unique case (m)
         TTC_M13:   step = {c13[13], c13[12:5], lo[7:5], c13[4:0]};
         TTC_M16:   step = c16;
         TTC_M8RLD: step = c8[8] ? {1'b1, hi, hi} : {1'b0, hi, c8[7:0]};
         TTC_SPLIT: step = {c8[8], hi, c8[7:0]};
      endcase
   endfunction : step

   logic [16:0] n1, n2, n3;
   logic [8:0]  n1h;
   logic        wr_hit;
   assign n1  = step(cfg1_reg.mode, lo1_reg, hi1_reg);
   assign n2  = step(cfg2_reg.mode, lo2_reg, hi2_reg);
   assign n1h = {1'b0, hi1_reg} + 9'h1;
   assign n3  = {1'b0, hi3_reg, lo3_reg} + 17'h1;
   assign wr_hit = wr_en & (addr == ADDR_RUN_FLAG);

   logic ovf1, ovf1h, ovf2, ovf3, trig3;
   assign ovf1  = en1 & n1[16];
   assign ovf1h = en1h & n1h[8];
   assign ovf2  = en2 & n2[16] & ~split1;
   assign ovf3  = inc3 & n3[16];
   assign trig3 = t3_ctrl_reg[T3_TRIGEN_BIT] & fall[5];

   function automatic logic wr(input logic [7:0] a);
      wr = wr_en & (addr == a);
   endfunction : wr

   // first and second timer counters; hardware wins over writes
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lo1_reg <= REG_RESET;
         hi1_reg <= REG_RESET;
      end else begin
         if (en1) begin
            lo1_reg <= n1[7:0];
            if (!split1) begin
               hi1_reg <= n1[15:8];
            end
         end else if (wr(ADDR_LOW_1)) begin
            lo1_reg <= wdata;
         end
         if (en1h) begin
            hi1_reg <= n1h[7:0];
         end else if (wr(ADDR_HIGH_1) && !(en1 && !split1)) begin
            hi1_reg <= wdata;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lo2_reg <= REG_RESET;
         hi2_reg <= REG_RESET;
      end else if (en2) begin
         lo2_reg <= n2[7:0];
         hi2_reg <= n2[15:8];
      end else begin
         if (wr(ADDR_LOW_2)) begin
            lo2_reg <= wdata;
         end
         if (wr(ADDR_HIGH_2)) begin
            hi2_reg <= wdata;
         end
      end
   end

   // third timer counter, reload and capture
   logic cap_mode;
   assign cap_mode = t3_ctrl_reg[T3_CAP_BIT];
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         lo3_reg <= REG_RESET;
         hi3_reg <= REG_RESET;
      end else if (!cap_mode && (ovf3 || trig3)) begin
         lo3_reg <= rld_lo_reg;
         hi3_reg <= rld_hi_reg;
      end else if (inc3) begin
         lo3_reg <= n3[7:0];
         hi3_reg <= n3[15:8];
      end else begin
         if (wr(ADDR_LOW_3)) begin
            lo3_reg <= wdata;
         end
         if (wr(ADDR_HIGH_3)) begin
            hi3_reg <= wdata;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rld_lo_reg <= REG_RESET;
         rld_hi_reg <= REG_RESET;
      end else if (cap_mode && trig3) begin
         rld_lo_reg <= lo3_reg;
         rld_hi_reg <= hi3_reg;
      end else begin
         if (wr(ADDR_RLD_LOW3)) begin
            rld_lo_reg <= wdata;
         end
         if (wr(ADDR_RLD_HIGH3)) begin
            rld_hi_reg <= wdata;
         end
      end
   end

   // control and flag registers; a set beats a software clear
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         run_flag_reg <= REG_RESET;
         t3_ctrl_reg  <= REG_RESET;
      end else begin
         if (wr(ADDR_RUN_FLAG)) begin
            run_flag_reg <= wdata;
         end
         if (ovf1) begin
            run_flag_reg[OVF1_BIT] <= 1'b1;
         end
         if (ovf2 || ovf1h) begin
            run_flag_reg[OVF2_BIT] <= 1'b1;
         end
         if (wr(ADDR_T3_CTRL)) begin
            t3_ctrl_reg <= wdata;
         end
         if (ovf3) begin
            t3_ctrl_reg[T3_OVF_BIT] <= 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         cfg1_reg     <= ttc_cfg_s'(4'h0);
         cfg2_reg     <= ttc_cfg_s'(4'h0);
         clk_div_reg  <= REG_RESET;
         clk_fast_reg <= REG_RESET;
         t3_opt_reg   <= REG_RESET;
      end else begin
         if (wr(ADDR_MODE_CFG)) begin
            cfg1_reg <= ttc_cfg_s'(wdata[3:0]);
            cfg2_reg <= ttc_cfg_s'(wdata[7:4]);
         end
         if (wr(ADDR_CLK_DIV)) begin
            clk_div_reg <= wdata;
         end
         if (wr(ADDR_CLK_FAST)) begin
            clk_fast_reg <= wdata;
         end
         if (wr(ADDR_T3_OPT)) begin
            t3_opt_reg <= wdata;
         end
      end
   end

   // read port and flag outputs
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdata      <= 8'h00;
         ovf_first  <= 1'b0;
         ovf_second <= 1'b0;
         ovf_third  <= 1'b0;
      end else begin
         ovf_first  <= run_flag_reg[OVF1_BIT];
         ovf_second <= run_flag_reg[OVF2_BIT];
         ovf_third  <= t3_ctrl_reg[T3_OVF_BIT];
         rdata      <= 8'h00;
         if (rd_en) begin
            case (addr)
               ADDR_RUN_FLAG:  rdata <= run_flag_reg;
               ADDR_MODE_CFG:  rdata <= {cfg2_reg, cfg1_reg};
               ADDR_LOW_1:     rdata <= lo1_reg;
               ADDR_LOW_2:     rdata <= lo2_reg;
               ADDR_HIGH_1:    rdata <= hi1_reg;
               ADDR_HIGH_2:    rdata <= hi2_reg;
               ADDR_CLK_DIV:   rdata <= clk_div_reg;
               ADDR_CLK_FAST:  rdata <= clk_fast_reg;
               ADDR_T3_CTRL:   rdata <= t3_ctrl_reg;
               ADDR_T3_OPT:    rdata <= t3_opt_reg;
               ADDR_RLD_LOW3:  rdata <= rld_lo_reg;
               ADDR_RLD_HIGH3: rdata <= rld_hi_reg;
               ADDR_LOW_3:     rdata <= lo3_reg;
               ADDR_HIGH_3:    rdata <= hi3_reg;
               default:        rdata <= 8'h00;
            endcase
         end
      end
   end

   // checks
   ovf1_sets_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
      ovf1 |=> run_flag_reg[OVF1_BIT])
      else $error("first overflow did not set flag");
   ovf3_sets_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
      ovf3 |=> t3_ctrl_reg[T3_OVF_BIT])
      else $error("third overflow did not set flag");
   t3_reload_a: assert property (@(posedge ref_clk) disable iff (rst)
      (!cap_mode && trig3) |=> {hi3_reg, lo3_reg} == $past({rld_hi_reg,
      rld_lo_reg}))
      else $error("forced reload missing");
   t3_capture_a: assert property (@(posedge ref_clk) disable iff (rst)
      (cap_mode && trig3) |=> rld_lo_reg == $past(lo3_reg))
      else $error("capture missing");
   t3_stop_a: assert property (@(posedge ref_clk) disable iff (rst)
      (!t3_ctrl_reg[T3_RUN_BIT] && !trig3 && !wr_en) |=> $stable(lo3_reg))
      else $error("third timer moved while stopped");
   second_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
      (cfg2_reg.mode == TTC_SPLIT && !wr_en) |=> $stable(lo2_reg))
      else $error("second timer moved in split");
   split_noflag_a: assert property (@(posedge ref_clk) disable iff (rst)
      (split1 && !ovf1h && !wr_hit) |=> $stable(run_flag_reg[OVF2_BIT]))
      else $error("second timer flagged in split");
   m8_reload_a: assert property (@(posedge ref_clk) disable iff (rst)
      (cfg1_reg.mode == TTC_M8RLD && en1 && lo1_reg == 8'hFF)
      |=> lo1_reg == $past(hi1_reg))
      else $error("8-bit reload missing");
endmodule : ttc_top

/* design/ttc_pkg.sv */
/*
 * ttc_pkg: shared constants and types for the triple timer/counter.
 * Assumes an 8-bit register port with byte addresses as below.
 */
package ttc_pkg;
   localparam logic [7:0] ADDR_RUN_FLAG  = 8'h88;
   localparam logic [7:0] ADDR_MODE_CFG  = 8'h89;
   localparam logic [7:0] ADDR_LOW_1     = 8'h8A;
   localparam logic [7:0] ADDR_LOW_2     = 8'h8B;
   localparam logic [7:0] ADDR_HIGH_1    = 8'h8C;
   localparam logic [7:0] ADDR_HIGH_2    = 8'h8D;
   localparam logic [7:0] ADDR_CLK_DIV   = 8'h8E;
   localparam logic [7:0] ADDR_CLK_FAST  = 8'h96;
   localparam logic [7:0] ADDR_T3_CTRL   = 8'hC8;
   localparam logic [7:0] ADDR_T3_OPT    = 8'hC9;
   localparam logic [7:0] ADDR_RLD_LOW3  = 8'hCA;
   localparam logic [7:0] ADDR_RLD_HIGH3 = 8'hCB;
   localparam logic [7:0] ADDR_LOW_3     = 8'hCC;
   localparam logic [7:0] ADDR_HIGH_3    = 8'hCD;

   // bit positions
   localparam int RUN1_BIT = 4;
   localparam int OVF1_BIT = 5;
   localparam int RUN2_BIT = 6;
   localparam int OVF2_BIT = 7;
   localparam int T3_OVF_BIT = 7;
   localparam int T3_TRIGEN_BIT = 3;
   localparam int T3_RUN_BIT = 2;
   localparam int T3_SRC_BIT = 1;
   localparam int T3_CAP_BIT = 0;
   localparam int QUARTER_BIT0 = 3;
   localparam int FULL_BIT0 = 3;

   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int LEGACY_DIV = 12;
   localparam int QUARTER_DIV = 4;

   typedef enum logic [1:0] {
      TTC_M13   = 2'b00,
      TTC_M16   = 2'b01,
      TTC_M8RLD = 2'b10,
      TTC_SPLIT = 2'b11
   } ttc_mode_e;

   typedef struct packed {
      logic gate;
      logic src;
      ttc_mode_e mode;
   } ttc_cfg_s;
endpackage : ttc_pkg

/* verif/ttc_pins.sv */
/*
 * ttc_pins: far-side model of the count, gate and trigger pins.
 * Assumes pulled-up port lines that idle high; changes at rising edges.
 */
`timescale 1ns/1ps
module ttc_pins (
   input  wire logic ref_clk,
   output logic       ext_irq_pin_a,
   output logic       ext_irq_pin_b,
   output logic [2:0] cnt_pins,
   output logic       trigger_pin_third
);
   initial begin
      ext_irq_pin_a     = 1'b1;
      ext_irq_pin_b     = 1'b1;
      cnt_pins          = 3'h7;
      trigger_pin_third = 1'b1;
   end

   // gate qualifier levels
   task automatic set_gate(input logic a, input logic b);
      @(posedge ref_clk);
      ext_irq_pin_a <= a;
      ext_irq_pin_b <= b;
   endtask : set_gate

   // sel 0..2 count pins, 3 trigger; low held four clocks, high five between pulses
   task automatic pulse(input int sel, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge ref_clk);
         if (sel == 3) trigger_pin_third <= 1'b0;
         else cnt_pins[sel] <= 1'b0;
         repeat (4) @(posedge ref_clk);
         if (sel == 3) trigger_pin_third <= 1'b1;
         else cnt_pins[sel] <= 1'b1;
         repeat (4) @(posedge ref_clk);
      end
   endtask : pulse
endmodule : ttc_pins

/* verif/tb_top.sv */
/*
 * tb_top: self-checking bench for the triple timer/counter.
 * Assumes ttc_top and ttc_pins; reads checked through a note queue.
 */
`timescale 1ns/1ps
module tb_top;
   import ttc_pkg::*;
   typedef struct packed {
      logic [7:0] lo;
      logic [7:0] hi;
      logic [7:0] mask;
   } ttc_note_s;
   localparam int CYC_MAX = 20000;
   logic        ref_clk, rst, wr_en, rd_en, rd_seen;
   logic [7:0]  addr, wdata, rdata, nv;
   logic        ovf_first, ovf_second, ovf_third;
   logic        gate_a, gate_b, trig;
   logic [2:0]  cnt_pins;
   logic [15:0] seed;
   int          err_total, cmp_count, cyc_count;
   ttc_note_s   note_q[$];
   logic [7:0]  regs[6] = '{ADDR_RUN_FLAG, ADDR_MODE_CFG, ADDR_CLK_DIV,
                           ADDR_CLK_FAST, ADDR_T3_CTRL, ADDR_LOW_3};
   logic [7:0]  tb_div[3] = '{8'h00, 8'h20, 8'h20};
   logic [7:0]  tb_fast[3] = '{8'h00, 8'h00, 8'h20};
   logic [7:0]  tb_lo[3] = '{8'h09, 8'h1C, 8'h76};
   logic [7:0]  tb_hi[3] = '{8'h0B, 8'h20, 8'h7C};

   ttc_top i_ttc_top (.ref_clk(ref_clk), .rst(rst), .addr(addr),
      .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
      .ext_irq_pin_a(gate_a), .ext_irq_pin_b(gate_b),
      .count_pin_first(cnt_pins[0]), .count_pin_second(cnt_pins[1]),
      .count_pin_third(cnt_pins[2]), .trigger_pin_third(trig),
      .ovf_first(ovf_first), .ovf_second(ovf_second),
      .ovf_third(ovf_third));
   ttc_pins i_ttc_pins (.ref_clk(ref_clk), .ext_irq_pin_a(gate_a),
      .ext_irq_pin_b(gate_b), .cnt_pins(cnt_pins),
      .trigger_pin_third(trig));

   always #2.5 ref_clk = ~ref_clk;

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   task automatic finish_test;
      $display("compares %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : finish_test

   task automatic chk_rd(input logic [7:0] got);
      ttc_note_s n;
      logic      ok;
      cmp_count++;
      if (note_q.size() == 0) begin
         err_total++;
         $display("mismatch %0t: read with no note", $time);
      end else begin
         n  = note_q.pop_front();
         ok = ((got & n.mask) >= n.lo) && ((got & n.mask) <= n.hi);
         if (ok !== 1'b1) begin
            err_total++;
            $display("mismatch %0t: read %h not in %h..%h", $time, got,
                     n.lo, n.hi);
         end
      end
   endtask : chk_rd

   task automatic chk_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %0t: flag %b expected %b", $time, got, exp);
      end
   endtask : chk_bit

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      addr  <= a;
      wdata <= d;
      wr_en <= 1'b1;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] lo,
                     input logic [7:0] hi, input logic [7:0] m);
      note_q.push_back('{lo: lo, hi: hi, mask: m});
      @(posedge ref_clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk);
      rd_en <= 1'b0;
   endtask : rd

   task automatic settle;
      repeat (8) @(posedge ref_clk);
   endtask : settle

   // results appear one cycle after the read strobe
   always @(posedge ref_clk) begin
      if (rd_seen) chk_rd(rdata);
      rd_seen <= rd_en;
      cyc_count <= cyc_count + 1;
      if (cyc_count == CYC_MAX) begin
         err_total++;
         finish_test();
      end
   end

   initial begin
      ref_clk = 1'b0; rst = 1'b1; addr = 8'h00; wdata = 8'h00;
      wr_en = 1'b0; rd_en = 1'b0; rd_seen = 1'b0; cyc_count = 0;
      err_total = 0; cmp_count = 0; seed = 16'h1839;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      foreach (regs[i]) rd(regs[i], REG_RESET, REG_RESET, 8'hFF);
      rd(8'h00, 8'h00, 8'h00, 8'hFF);
      // counter mode, random pulse count
      seed = lfsr(seed);
      nv = {5'h00, seed[2:0]} + 8'h01;
      wr(ADDR_MODE_CFG, 8'h05);
      wr(ADDR_RUN_FLAG, 8'h10);
      i_ttc_pins.pulse(0, int'(nv));
      settle();
      rd(ADDR_LOW_1, nv, nv, 8'hFF);
      // gate held low blocks counting
      wr(ADDR_MODE_CFG, 8'h0D);
      i_ttc_pins.set_gate(1'b0, 1'b1);
      i_ttc_pins.pulse(0, 2);
      settle();
      rd(ADDR_LOW_1, nv, nv, 8'hFF);
      i_ttc_pins.set_gate(1'b1, 1'b1);
      settle();
      i_ttc_pins.pulse(0, 1);
      settle();
      rd(ADDR_LOW_1, nv + 8'h01, nv + 8'h01, 8'hFF);
      // 13-bit rollover
      wr(ADDR_RUN_FLAG, 8'h00);
      wr(ADDR_MODE_CFG, 8'h04);
      wr(ADDR_LOW_1, 8'h1F);
      wr(ADDR_HIGH_1, 8'hFF);
      wr(ADDR_RUN_FLAG, 8'h10);
      i_ttc_pins.pulse(0, 1);
      settle();
      chk_bit(ovf_first, 1'b1);
      rd(ADDR_LOW_1, 8'h00, 8'h00, 8'h1F);
      rd(ADDR_HIGH_1, 8'h00, 8'h00, 8'hFF);
      wr(ADDR_RUN_FLAG, 8'h00);
      settle();
      chk_bit(ovf_first, 1'b0);
      wr(ADDR_RUN_FLAG, 8'h20);
      settle();
      chk_bit(ovf_first, 1'b1);
      // first timer 8-bit autoreload from pin
      wr(ADDR_RUN_FLAG, 8'h00);
      wr(ADDR_MODE_CFG, 8'h06);
      wr(ADDR_LOW_1, 8'hFF);
      wr(ADDR_HIGH_1, 8'hFF);
      wr(ADDR_RUN_FLAG, 8'h10);
      i_ttc_pins.pulse(0, 1);
      settle();
      chk_bit(ovf_first, 1'b1);
      rd(ADDR_LOW_1, 8'hFF, 8'hFF, 8'hFF);
      // second timer: autoreload then 16-bit rollover
      wr(ADDR_RUN_FLAG, 8'h00);
      wr(ADDR_MODE_CFG, 8'h60);
      wr(ADDR_LOW_2, 8'hFE);
      wr(ADDR_HIGH_2, 8'hFE);
      wr(ADDR_RUN_FLAG, 8'h40);
      i_ttc_pins.pulse(1, 2);
      settle();
      chk_bit(ovf_second, 1'b1);
      rd(ADDR_LOW_2, 8'hFE, 8'hFE, 8'hFF);
      rd(ADDR_HIGH_2, 8'hFE, 8'hFE, 8'hFF);
      wr(ADDR_RUN_FLAG, 8'h00);
      wr(ADDR_MODE_CFG, 8'h50);
      wr(ADDR_LOW_2, 8'hFF);
      wr(ADDR_HIGH_2, 8'hFF);
      wr(ADDR_RUN_FLAG, 8'h40);
      i_ttc_pins.pulse(1, 1);
      settle();
      chk_bit(ovf_second, 1'b1);
      rd(ADDR_LOW_2, 8'h00, 8'h00, 8'hFF);
      rd(ADDR_HIGH_2, 8'h00, 8'h00, 8'hFF);
      // third timer: overflow reload, trigger reload, capture
      wr(ADDR_RUN_FLAG, 8'h00);
      wr(ADDR_RLD_LOW3, 8'h34);
      wr(ADDR_RLD_HIGH3, 8'h12);
      wr(ADDR_LOW_3, 8'hFF);
      wr(ADDR_HIGH_3, 8'hFF);
      wr(ADDR_T3_CTRL, 8'h06);
      i_ttc_pins.pulse(2, 1);
      settle();
      chk_bit(ovf_third, 1'b1);
      rd(ADDR_LOW_3, 8'h34, 8'h34, 8'hFF);
      rd(ADDR_HIGH_3, 8'h12, 8'h12, 8'hFF);
      i_ttc_pins.pulse(2, 1);
      i_ttc_pins.pulse(3, 1);
      settle();
      rd(ADDR_LOW_3, 8'h35, 8'h35, 8'hFF);
      wr(ADDR_T3_CTRL, 8'h0E);
      i_ttc_pins.pulse(3, 1);
      settle();
      rd(ADDR_LOW_3, 8'h34, 8'h34, 8'hFF);
      seed = lfsr(seed);
      wr(ADDR_T3_CTRL, 8'h0F);
      wr(ADDR_LOW_3, seed[7:0]);
      wr(ADDR_HIGH_3, 8'h00);
      i_ttc_pins.pulse(3, 1);
      settle();
      rd(ADDR_RLD_LOW3, seed[7:0], seed[7:0], 8'hFF);
      rd(ADDR_RLD_HIGH3, 8'h00, 8'h00, 8'hFF);
      wr(ADDR_T3_CTRL, 8'h02);
      i_ttc_pins.pulse(2, 2);
      settle();
      rd(ADDR_LOW_3, seed[7:0], seed[7:0], 8'hFF);
      // time base: /12, /4, /1 with quarter bit ignored
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_CLK_DIV, tb_div[i]);
         wr(ADDR_CLK_FAST, tb_fast[i]);
         wr(ADDR_LOW_3, 8'h00);
         wr(ADDR_T3_CTRL, 8'h04);
         repeat (120) @(posedge ref_clk);
         wr(ADDR_T3_CTRL, 8'h00);
         rd(ADDR_LOW_3, tb_lo[i], tb_hi[i], 8'hFF);
      end
      // split mode: first high byte on second run bit, second held
      wr(ADDR_CLK_FAST, 8'h38);
      wr(ADDR_LOW_2, 8'h5A);
      wr(ADDR_HIGH_1, 8'hF0);
      wr(ADDR_MODE_CFG, 8'h33);
      wr(ADDR_RUN_FLAG, 8'h40);
      repeat (30) @(posedge ref_clk);
      chk_bit(ovf_second, 1'b1);
      rd(ADDR_LOW_2, 8'h5A, 8'h5A, 8'hFF);
      // first split, second in 16-bit mode: clocks only, no flag
      wr(ADDR_LOW_2, 8'hFF);
      wr(ADDR_HIGH_2, 8'hFF);
      wr(ADDR_RUN_FLAG, 8'h00);
      wr(ADDR_MODE_CFG, 8'h13);
      settle();
      chk_bit(ovf_second, 1'b0);
      rd(ADDR_LOW_2, 8'h02, 8'h20, 8'hFF);
      settle();
      finish_test();
   end
endmodule : tb_top
